// [hw/duart_pkg.sv]
// Constants, carrier structs and state types for the dual serial transceiver host glue
// What this block does
// - Chip select low selects device; channel pick 1 is channel A, 0 channel B.
// - Host port: 8-bit bidirectional data, 3-bit address, select and strobes.
// - Bus cycles need no oscillator; framed by select, pick and strobes only.
// - Channels share the data bus; only the picked channel answers or drives.
// - Reset pin acts only when held high longer than 40 ns.
// - Reset returns registers and serial outputs of both channels to defaults.
// - With both divisor bytes zero, high reads identity, low reads revision.
// - Each channel owns its register set; writing one leaves the other alone unless the picked channel's alternate function bit 0 is set.
// - Each channel has 128-byte transmit and receive FIFOs.
// - Per-channel prescaler divides oscillator by 1 or 4.
// - Bits are timed by a sampling tick at sixteen times the data rate.
// - Auto direction goes to receive after last stop bit leaves.
// - Auto direction goes to transmit when a byte loads the transmitter.
// - Auto direction off after reset; feature control bit 3 enables it.
// - Direction output high means receive, low means transmit.
// - Alternate function bit 0 makes writes reach both channels.
package duart_pkg;
   // Register addresses (LCR bit 7 switches banks)
   localparam logic [2:0] A_DATA     = 3'h0;
   localparam logic [2:0] A_DIV_HIGH = 3'h1;
   localparam logic [2:0] A_ALT_FUNC = 3'h2;
   localparam logic [2:0] A_LCR      = 3'h3;
   localparam logic [2:0] A_MCR      = 3'h4;
   localparam logic [2:0] A_LSR      = 3'h5;
   localparam logic [2:0] A_SPR_FEAT = 3'h7;
   // Field positions
   localparam int LCR_BANK     = 7;
   localparam int MCR_RTS      = 1;
   localparam int MCR_PRESC    = 7;
   localparam int FEAT_AUTODIR = 3;
   localparam int ALT_BOTH     = 0;
   // Reset value of every channel register
   localparam logic [7:0] REG_RST = 8'h00;
   // FIFO, bit timing and reset filter
   localparam logic [7:0] FIFO_FULL  = 8'h80;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [3:0] SUB_LAST   = 4'hf;
   localparam logic [3:0] SUB_MID    = 4'h7;
   localparam logic [3:0] FRAME_LAST = 4'h9;
   localparam int CLK_NS       = 10;
   localparam int RESET_MIN_NS = 40;
   localparam logic [2:0] RESET_MIN_CYC = 3'((RESET_MIN_NS + CLK_NS - 1) / CLK_NS);

   typedef struct packed {
      logic       cs_n;
      logic       channel_pick;
      logic [2:0] addr;
      logic       read_strobe_n;
      logic       write_strobe_n;
      logic [7:0] data;
   } host_in_t;

   // Idle level of the host pins: deselected, both strobes high
   localparam host_in_t HOST_IDLE = '{cs_n: 1'b1, channel_pick: 1'b0, addr: 3'h0,
                                      read_strobe_n: 1'b1, write_strobe_n: 1'b1,
                                      data: 8'h00};

   typedef struct packed {
      logic [7:0]            dll, divisor_high, lcr, mcr, feature_ctrl_reg, alt_function_reg, spr;
      logic [127:0][7:0]     txm, rxm;
      logic [6:0]            twp, trp, rwp, rrp;
      logic [7:0]            tcnt, rcnt;
      logic [1:0]            pre_cnt;
      logic [15:0]           div_cnt;
      logic                  tx_busy, tx_dir;
      logic [3:0]            tx_sub, tx_bit;
      logic [9:0]            tx_sh;
      logic                  rx_busy, rx_ovr;
      logic [3:0]            rx_sub, rx_bit;
      logic [7:0]            rx_sh;
   } chan_t;

   typedef struct packed {
      host_in_t              s1, s2, s3;
      logic [2:0]            osc_s;
      logic [1:0]            res_s;
      logic [2:0]            rst_cnt;
      logic                  dev_rst;
      logic [1:0][1:0]       rxd_s;
      logic [7:0]            dout;
      logic                  oe;
      chan_t [1:0]           ch;
   } state_t;
endpackage

// [hw/dual_uart_host_select.sv]
// Host bus glue, reset filter and two serial channels of the dual transceiver
`timescale 1ns/1ps
module dual_uart_host_select #(
   parameter logic [7:0] DEVICE_ID   = 8'h5a, // Arbitrary value
   parameter logic [7:0] REVISION_ID = 8'h03  // Arbitrary value
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire duart_pkg::host_in_t host_in,
   output logic [7:0]               data_out,
   output logic                     data_oe,
   input  wire logic                reset_in,
   input  wire logic                osc_input,
   input  wire logic [1:0]          rxd,
   output logic [1:0]               txd,
   output logic [1:0]               dir
);
   import duart_pkg::*;

   state_t     q;
   state_t     d;
   logic [1:0] rst_sync_q;
   logic       rst_q;

   // Register read decode, identity shown when both divisor bytes are zero
   function automatic logic [7:0] reg_read(chan_t c, logic [2:0] a);
      logic bank;
      logic id_mode;
      logic [7:0] r;
      bank = c.lcr[LCR_BANK];
      id_mode = (c.dll == 8'h00) && (c.divisor_high == 8'h00);
      r = 8'h00;
      unique case (a)
         A_DATA:     r = bank ? (id_mode ? REVISION_ID : c.dll)
                              : ((c.rcnt != 8'h00) ? c.rxm[c.rrp] : 8'h00);
         A_DIV_HIGH: r = bank ? (id_mode ? DEVICE_ID : c.divisor_high) : 8'h00;
         A_ALT_FUNC: r = bank ? c.alt_function_reg : 8'h00;
         A_LCR:      r = c.lcr;
         A_MCR:      r = c.mcr;
         A_LSR:      r = {1'b0, (c.tcnt == 8'h00) && !c.tx_busy, c.tcnt != FIFO_FULL,
                          3'h0, c.rx_ovr, c.rcnt != 8'h00};
         3'h6:       r = 8'h00;
         A_SPR_FEAT: r = bank ? c.feature_ctrl_reg : c.spr;
      endcase
      return r;
   endfunction

   // Reset release through two flops so every flop leaves reset on the same edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_q = rst_sync_q[1];

   // Next state of the whole block
   always_comb begin
      logic       sel;
      logic       wr_ev;
      logic       rd_ev;
      logic       pick;
      logic       both;
      logic       osc_tick;
      logic       pre_tick;
      logic       tick;
      logic       wr;
      logic       rd;
      logic       bank;
      logic       rxs;
      logic       tpush;
      logic       tpop;
      logic       rpush;
      logic       rpop;
      logic [15:0] divisor;
      chan_t      c;
      sel = 1'b0;
      wr_ev = 1'b0;
      rd_ev = 1'b0;
      pick = 1'b0;
      both = 1'b0;
      osc_tick = 1'b0;
      pre_tick = 1'b0;
      tick = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      bank = 1'b0;
      rxs = 1'b1;
      tpush = 1'b0;
      tpop = 1'b0;
      rpush = 1'b0;
      rpop = 1'b0;
      divisor = 16'h0000;
      c = '0;
      d = q;
      // bus pins are sampled on the block clock, never the oscillator
      d.s1 = host_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.osc_s = {q.osc_s[1:0], osc_input};
      d.res_s = {q.res_s[0], reset_in};
      for (int i = 0; i < 2; i++) begin
         d.rxd_s[i] = {q.rxd_s[i][0], rxd[i]};
      end
      // reset pin must stay high more than the minimum before it acts
      if (q.res_s[1]) begin
         if (q.rst_cnt != RESET_MIN_CYC) begin
            d.rst_cnt = q.rst_cnt + 3'h1;
         end
      end else begin
         d.rst_cnt = 3'h0;
      end
      d.dev_rst = q.res_s[1] && (q.rst_cnt == RESET_MIN_CYC);
      // select decode; channel A is index 0, picked by a high level
      sel = !q.s2.cs_n;
      pick = !q.s2.channel_pick;
      // Strobe ends commit the access, so address and data have settled by then
      wr_ev = sel && q.s2.write_strobe_n && !q.s3.write_strobe_n;
      rd_ev = sel && q.s2.read_strobe_n && !q.s3.read_strobe_n;
      // broadcast write override of the picked channel
      both = q.ch[pick].alt_function_reg[ALT_BOTH];
      osc_tick = q.osc_s[1] && !q.osc_s[2];
      // only the picked channel drives read data
      d.oe = sel && !q.s2.read_strobe_n;
      d.dout = reg_read(q.ch[pick], q.s2.addr);

      // each channel updates from its own state, except the broadcast bit, which comes from the picked channel
      for (int i = 0; i < 2; i++) begin
         c = q.ch[i];
         tpush = 1'b0;
         tpop = 1'b0;
         rpush = 1'b0;
         rpop = 1'b0;
         tick = 1'b0;
         wr = wr_ev && ((1'(i) == pick) || both);
         rd = rd_ev && (1'(i) == pick);
         bank = c.lcr[LCR_BANK];
         rxs = q.rxd_s[i][1];
         // Host writes; a full transmit FIFO drops the byte
         if (wr) begin
            unique case (q.s2.addr)
               A_DATA: begin
                  if (bank) begin
                     c.dll = q.s2.data;
                  end else if (c.tcnt != FIFO_FULL) begin
                     c.txm[c.twp] = q.s2.data;
                     c.twp = c.twp + 7'h01;
                     tpush = 1'b1;
                  end
               end
               A_DIV_HIGH: if (bank) c.divisor_high = q.s2.data;
               A_ALT_FUNC: if (bank) c.alt_function_reg = q.s2.data;
               A_LCR: c.lcr = q.s2.data;
               A_MCR: c.mcr = q.s2.data;
               A_SPR_FEAT: begin
                  if (bank) begin
                     c.feature_ctrl_reg = q.s2.data;
                  end else begin
                     c.spr = q.s2.data;
                  end
               end
               default: ;
            endcase
         end
         // Host reads with side effects: pop receive data, clear overrun
         if (rd && (q.s2.addr == A_DATA) && !bank && (c.rcnt != 8'h00)) begin
            c.rrp = c.rrp + 7'h01;
            rpop = 1'b1;
         end
         if (rd && (q.s2.addr == A_LSR)) begin
            c.rx_ovr = 1'b0;
         end
         // prescaler divides oscillator edges by 1 or 4
         pre_tick = osc_tick && (!c.mcr[MCR_PRESC] || (c.pre_cnt == PRESC_LAST));
         if (osc_tick) begin
            c.pre_cnt = pre_tick ? 2'h0 : c.pre_cnt + 2'h1;
         end
         // divisor yields the sixteen-times sampling tick; zero stops it
         divisor = {c.divisor_high, c.dll};
         if (pre_tick && (divisor != 16'h0000)) begin
            if (c.div_cnt >= divisor - 16'h0001) begin
               c.div_cnt = 16'h0000;
               tick = 1'b1;
            end else begin
               c.div_cnt = c.div_cnt + 16'h0001;
            end
         end
         // Transmitter: 8N1 frame, start bit first
         if (!c.tx_busy && (c.tcnt != 8'h00)) begin
            c.tx_sh = {1'b1, c.txm[c.trp], 1'b0};
            c.trp = c.trp + 7'h01;
            tpop = 1'b1;
            c.tx_busy = 1'b1;
            c.tx_sub = 4'h0;
            c.tx_bit = 4'h0;
            // loading a byte turns the line to transmit
            if (c.feature_ctrl_reg[FEAT_AUTODIR]) c.tx_dir = 1'b1;
         end else if (c.tx_busy && tick) begin
            if (c.tx_sub == SUB_LAST) begin
               c.tx_sh = {1'b1, c.tx_sh[9:1]};
               if (c.tx_bit == FRAME_LAST) begin
                  c.tx_busy = 1'b0;
                  // back to receive once the last stop bit is out
                  if (c.feature_ctrl_reg[FEAT_AUTODIR] && (c.tcnt == 8'h00)) c.tx_dir = 1'b0;
               end else begin
                  c.tx_bit = c.tx_bit + 4'h1;
               end
            end
            c.tx_sub = c.tx_sub + 4'h1;
         end
         // without auto mode the direction follows the RTS bit
         if (!c.feature_ctrl_reg[FEAT_AUTODIR]) c.tx_dir = c.mcr[MCR_RTS];
         // Receiver: start found on a tick, each bit sampled mid-cell
         if (tick) begin
            if (!c.rx_busy) begin
               if (!rxs) begin
                  c.rx_busy = 1'b1;
                  c.rx_sub = 4'h0;
                  c.rx_bit = 4'h0;
               end
            end else begin
               if (c.rx_sub == SUB_MID) begin
                  if (c.rx_bit == 4'h0) begin
                     if (rxs) c.rx_busy = 1'b0; // Glitch, not a start bit
                  end else if (c.rx_bit == FRAME_LAST) begin
                     c.rx_busy = 1'b0;
                     // Overrun set after the read clear, so a same-cycle event wins
                     if (c.rcnt != FIFO_FULL || rpop) begin
                        c.rxm[c.rwp] = c.rx_sh;
                        c.rwp = c.rwp + 7'h01;
                        rpush = 1'b1;
                     end else begin
                        c.rx_ovr = 1'b1;
                     end
                  end else begin
                     c.rx_sh = {rxs, c.rx_sh[7:1]};
                  end
               end
               if (c.rx_sub == SUB_LAST) c.rx_bit = c.rx_bit + 4'h1;
               c.rx_sub = c.rx_sub + 4'h1;
            end
         end
         c.tcnt = c.tcnt + {7'h00, tpush} - {7'h00, tpop};
         c.rcnt = c.rcnt + {7'h00, rpush} - {7'h00, rpop};
         d.ch[i] = c;
      end
      // filtered reset pin clears both channels
      if (q.dev_rst) begin
         d.ch = '0;
      end
   end

   // State register; all-zero is the default of every channel register
   always_ff @(posedge clk or negedge rst_q) begin
      if (!rst_q) begin
         // Pin copies start at their idle level, so no false read drive follows reset
         q <= '0;
         q.s1 <= HOST_IDLE;
         q.s2 <= HOST_IDLE;
         q.s3 <= HOST_IDLE;
         q.rxd_s <= '1;
      end else begin
         q <= d;
      end
   end

   assign data_out = q.dout;
   assign data_oe  = q.oe;

   // Serial outputs idle high; direction pin high means receive
   for (genvar gi = 0; gi < 2; gi++) begin : g_ch
      assign txd[gi] = !q.ch[gi].tx_busy || q.ch[gi].tx_sh[0];
      assign dir[gi] = !q.ch[gi].tx_dir;

      a_reset_default: assert property (@(posedge clk) disable iff (!rst_q)
         q.dev_rst |=> (txd[gi] && dir[gi] && (q.ch[gi].tcnt == 8'h00)))
         else $error("channel not at default after reset");
      a_autodir_off: assert property (@(posedge clk) disable iff (!rst_q)
         q.dev_rst |=> (q.ch[gi].feature_ctrl_reg == REG_RST))
         else $error("auto direction not off after reset");
      a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_q)
         (q.ch[gi].tcnt <= FIFO_FULL) && (q.ch[gi].rcnt <= FIFO_FULL))
         else $error("FIFO count beyond 128");
      a_load_dir: assert property (@(posedge clk) disable iff (!rst_q)
         (q.ch[gi].feature_ctrl_reg[FEAT_AUTODIR] && !q.ch[gi].tx_busy
          && (q.ch[gi].tcnt != 8'h00) && !q.dev_rst) |=> (!dir[gi] && q.ch[gi].tx_busy))
         else $error("direction not transmit after load");
      a_release_dir: assert property (@(posedge clk) disable iff (!rst_q)
         ($fell(q.ch[gi].tx_busy) && q.ch[gi].feature_ctrl_reg[FEAT_AUTODIR]
          && (q.ch[gi].tcnt == 8'h00) && !$past(q.dev_rst)) |-> dir[gi])
         else $error("direction not receive after last stop bit");
      a_bit_time: assert property (@(posedge clk) disable iff (!rst_q)
         ($changed(q.ch[gi].tx_bit) && q.ch[gi].tx_busy && $past(q.ch[gi].tx_busy))
         |-> ($past(q.ch[gi].tx_sub) == SUB_LAST))
         else $error("bit cell not sixteen ticks");
   end

   a_deselect_quiet: assert property (@(posedge clk) disable iff (!rst_q)
      q.s2.cs_n |=> !data_oe)
      else $error("data driven while deselected");
   a_read_drive: assert property (@(posedge clk) disable iff (!rst_q)
      data_oe |-> (!$past(q.s2.cs_n) && !$past(q.s2.read_strobe_n)))
      else $error("data driven outside a read");
   a_reset_filter: assert property (@(posedge clk) disable iff (!rst_q)
      $rose(q.dev_rst) |-> ($past(q.res_s[1], 1) && $past(q.res_s[1], 5)))
      else $error("reset taken from short pulse");
endmodule

// [tb/host_bus_model.sv]
// Host processor model driving the asynchronous select, strobe and data pins
`timescale 1ns/1ps
module host_bus_model (
   input  wire logic         clk,
   input  wire logic [7:0]   data_out,
   input  wire logic         data_oe,
   output duart_pkg::host_in_t host_in
);
   import duart_pkg::*;
   logic       cs_n, pick, rd_n, wr_n, drv_en;
   logic [2:0] addr;
   logic [7:0] drv_d, last_q, level;
   // shared data wire
   // A released bus toggles each cycle so a stale value never reads back
   assign level = data_oe ? data_out : (drv_en ? drv_d : ~last_q);
   assign host_in = {cs_n, pick, addr, rd_n, wr_n, level};
   always @(posedge clk) last_q <= level;
   initial begin
      {cs_n, rd_n, wr_n, drv_en, pick, addr, drv_d, last_q} = {4'he, 20'h00000};
   end
   // low select picks the device
   // Pins move only at the falling edge; strobe held well past the sync chain
   task automatic cycle(input logic sel_n, input logic p, input logic [2:0] a,
                        input logic wr, input logic [7:0] d,
                        output logic [7:0] q, output logic oe);
      @(negedge clk);
      {cs_n, pick, addr, drv_d, drv_en} = {sel_n, p, a, d, wr};
      @(negedge clk);
      if (wr) wr_n = 1'b0;
      else rd_n = 1'b0;
      repeat (4) @(negedge clk);
      q = level;
      oe = data_oe;
      {rd_n, wr_n} = 2'b11;
      repeat (4) @(negedge clk);
      {cs_n, drv_en} = 2'b10;
      repeat (3) @(negedge clk);
   endtask
endmodule

// [tb/dual_uart_host_select_tb.sv]
// Self-checking bench for the dual transceiver host glue
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module dual_uart_host_select_tb;
   import duart_pkg::*;
   localparam logic [7:0] ID_V  = 8'ha7; // Arbitrary value
   localparam logic [7:0] REV_V = 8'h2c; // Arbitrary value
   logic       clk, rst_n, reset_in, osc_input, osc_run, oe, data_oe;
   logic [7:0] data_out, q;
   logic [1:0] txd, dir;
   host_in_t   host_in;
   int         miscompares, check_count;
   realtime    t_fall;

   // Channel B listens to channel A's line, so the receiver sees real frames
   dual_uart_host_select #(.DEVICE_ID(ID_V), .REVISION_ID(REV_V)) u_dut (
      .clk(clk), .rst_n(rst_n), .host_in(host_in), .data_out(data_out),
      .data_oe(data_oe), .reset_in(reset_in), .osc_input(osc_input),
      .rxd({txd[0], 1'b1}), .txd(txd), .dir(dir));
   host_bus_model u_host (
      .clk(clk), .data_out(data_out), .data_oe(data_oe), .host_in(host_in));

   // Clocks; the oscillator stays still until serial traffic is wanted
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      osc_input = 1'b0;
      forever #20 osc_input = osc_run ? ~osc_input : osc_input;
   end
   always @(negedge txd[0]) t_fall = $realtime;

   task automatic wr(input logic p, input logic [2:0] a, input logic [7:0] d);
      u_host.cycle(1'b0, p, a, 1'b1, d, q, oe);
   endtask
   task automatic rdc(input logic p, input logic [2:0] a, input logic [7:0] exp);
      u_host.cycle(1'b0, p, a, 1'b0, 8'h00, q, oe);
      `CHK(oe, 1'b1)
      `CHK(q, exp)
   endtask

   task automatic t_reset();
      `CHK(txd, 2'b11)
      `CHK(dir, 2'b11)
      `CHK(data_oe, 1'b0)
      $display("t_reset done");
   endtask
   // Bus work here runs with the oscillator stopped
   task automatic t_ident();
      wr(1'b1, A_LCR, 8'h80);
      wr(1'b1, A_DATA, 8'h00);
      wr(1'b1, A_DIV_HIGH, 8'h00);
      rdc(1'b1, A_DIV_HIGH, ID_V);
      rdc(1'b1, A_DATA, REV_V);
      // Channel B shows its identity only from its own divisor bank
      wr(1'b0, A_LCR, 8'h80);
      rdc(1'b0, A_DIV_HIGH, ID_V);
      wr(1'b0, A_LCR, 8'h00);
      // A nonzero low byte hides the identity again
      wr(1'b1, A_DATA, 8'h01);
      rdc(1'b1, A_DIV_HIGH, 8'h00);
      rdc(1'b1, A_DATA, 8'h01);
      wr(1'b1, A_LCR, 8'h00);
      $display("t_ident done");
   endtask
   task automatic t_select();
      wr(1'b1, A_SPR_FEAT, 8'h3c);
      wr(1'b0, A_SPR_FEAT, 8'hc3);
      rdc(1'b1, A_SPR_FEAT, 8'h3c);
      rdc(1'b0, A_SPR_FEAT, 8'hc3);
      u_host.cycle(1'b1, 1'b1, A_SPR_FEAT, 1'b1, 8'hff, q, oe);
      rdc(1'b1, A_SPR_FEAT, 8'h3c);
      u_host.cycle(1'b1, 1'b1, A_SPR_FEAT, 1'b0, 8'h00, q, oe);
      `CHK(oe, 1'b0)
      $display("t_select done");
   endtask
   // Writes through channel A reach B only while the both-channel bit is set
   task automatic t_both();
      wr(1'b1, A_LCR, 8'h80);
      wr(1'b1, A_ALT_FUNC, 8'h01);
      wr(1'b1, A_LCR, 8'h00);
      wr(1'b1, A_SPR_FEAT, 8'h69);
      rdc(1'b0, A_SPR_FEAT, 8'h69);
      wr(1'b1, A_LCR, 8'h80);
      wr(1'b1, A_ALT_FUNC, 8'h00);
      wr(1'b1, A_LCR, 8'h00);
      // The bank write above also reached channel B, so bring it back
      wr(1'b0, A_LCR, 8'h00);
      wr(1'b1, A_SPR_FEAT, 8'h11);
      rdc(1'b0, A_SPR_FEAT, 8'h69);
      $display("t_both done");
   endtask
   task automatic t_rts();
      wr(1'b0, A_MCR, 8'h02);
      `CHK(dir, 2'b01)
      wr(1'b0, A_MCR, 8'h00);
      `CHK(dir, 2'b11)
      $display("t_rts done");
   endtask
   // One frame on channel A, sampled mid-bit, with the direction pin tracked
   task automatic send(input logic [7:0] b, input realtime bit_ns);
      logic [9:0] fr;
      realtime    t0;
      realtime    tf;
      fr = {1'b1, b, 1'b0};
      t0 = $realtime;
      wr(1'b1, A_DATA, b);
      for (int i = 0; i < 100 && t_fall < t0; i++) @(negedge clk);
      // Data bits pull the line low too, so the timing keeps the start edge only
      tf = t_fall;
      `CHK(dir[0], 1'b0)
      for (int k = 0; k < 10; k++) begin
         #(tf + bit_ns * (k + 0.5) - $realtime);
         `CHK(txd[0], fr[k])
      end
      `CHK(dir[0], 1'b0)
      #(tf + bit_ns * 10 + 300 - $realtime);
      `CHK(dir[0], 1'b1)
   endtask
   task automatic t_tx();
      osc_run = 1'b1;
      wr(1'b1, A_LCR, 8'h80);
      wr(1'b1, A_DATA, 8'h01);
      wr(1'b1, A_DIV_HIGH, 8'h00);
      wr(1'b1, A_SPR_FEAT, 8'h08);
      wr(1'b1, A_LCR, 8'h00);
      // Channel B receives channel A's frame at the same rate
      wr(1'b0, A_LCR, 8'h80);
      wr(1'b0, A_DATA, 8'h01);
      wr(1'b0, A_LCR, 8'h00);
      send(8'ha5, 640.0);
      rdc(1'b0, A_LSR, 8'h61);
      rdc(1'b0, A_DATA, 8'ha5);
      rdc(1'b0, A_LSR, 8'h60);
      wr(1'b1, A_MCR, 8'h80);
      send(8'h3c, 2560.0);
      $display("t_tx done");
   endtask
   // A pulse of four samples is too short; six samples clear both channels
   task automatic pulse(input int n);
      @(negedge clk);
      reset_in = 1'b1;
      repeat (n) @(negedge clk);
      reset_in = 1'b0;
      repeat (20) @(negedge clk);
   endtask
   task automatic t_devrst();
      pulse(4);
      rdc(1'b1, A_SPR_FEAT, 8'h11);
      pulse(6);
      rdc(1'b1, A_SPR_FEAT, REG_RST);
      rdc(1'b0, A_SPR_FEAT, REG_RST);
      rdc(1'b0, A_LSR, 8'h60);
      `CHK({txd, dir}, 4'hf)
      $display("t_devrst done");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      {rst_n, reset_in, osc_run} = 3'b000;
      t_fall = 0.0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_ident();
      t_select();
      t_both();
      t_rts();
      t_tx();
      t_devrst();
      conclude();
   end
   // Whole run needs about 40 us
   initial begin
      #200us;
      miscompares++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
